// file: core/dacc_pkg.sv
// Constants, register map and state types for the dual converter control block
package dacc_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_CHAN_SEL  = 8'h05;
    localparam logic [7:0] ADDR_POWER     = 8'h08;
    localparam logic [7:0] ADDR_DCS       = 8'h09;
    localparam logic [7:0] ADDR_DIV       = 8'h0b;
    localparam logic [7:0] ADDR_STATUS    = 8'h0f;
    localparam logic [7:0] ADDR_OUT_MODE  = 8'h14;
    localparam logic [7:0] ADDR_ALIGN     = 8'h3a;
    localparam logic [7:0] ADDR_NSR       = 8'h3c;
    // Field positions
    localparam int OM_DISABLE_BIT  = 4;
    localparam int OM_DRIVE_BIT    = 3;
    localparam int ALIGN_EN_BIT    = 1;
    localparam int ALIGN_FIRST_BIT = 2;
    // Output formats, power modes
    localparam logic [1:0] FMT_OFFSET  = 2'h0;
    localparam logic [1:0] FMT_TWOS    = 2'h1;
    localparam logic [1:0] FMT_GRAY    = 2'h2;
    localparam logic [1:0] PWR_NORMAL  = 2'h0;
    localparam logic [1:0] PWR_DOWN    = 2'h1;
    localparam logic [1:0] PWR_STANDBY = 2'h2;
    // Reset values
    localparam logic [7:0] OUT_MODE_RST = 8'h01;
    localparam logic [7:0] ALIGN_RST    = 8'h00;
    localparam logic [1:0] CHAN_SEL_RST = 2'h3;
    localparam logic [2:0] DIV_SEL_RST  = 3'h0;
    // Pipeline latency in conversion cycles
    localparam int LAT_NORMAL = 10;
    localparam int LAT_NSR    = 13;
    // Stabilizer limits and relock wait
    localparam int CLK_MHZ     = 25;
    localparam int DCS_MIN_KHZ = 40000;
    localparam int RELOCK_NS   = 5000;
    localparam logic [7:0] RELOCK_CYC = 8'(RELOCK_NS * CLK_MHZ / 1000);

    // Register write request
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dacc_reg_req_t;

    // Whole block state
    typedef struct packed {
        logic [1:0]              align_sync;
        logic                    align_prev;
        logic [1:0]              pd_sync;
        logic [1:0]              oen_sync;
        logic                    align_armed;
        logic [1:0]              chan_sel;
        logic [1:0][7:0]         out_mode;
        logic [1:0]              nsr_en;
        logic [7:0]              align_ctl;
        logic [1:0]              pwr_mode;
        logic                    dcs_en;
        logic [2:0]              div_sel;
        logic [2:0]              div_cnt;
        logic [7:0]              relock_cnt;
        logic                    dcs_locked;
        logic                    conv_clk;
        logic [1:0][12:0][11:0]  dl;
        logic [1:0][11:0]        word;
        logic                    dcc;
        logic [10:0]             data_out;
        logic                    or_out;
        logic                    data_oe;
        logic                    drive_reduced;
        logic                    dcs_active;
        logic [7:0]              rdata;
    } dacc_state_t;
endpackage : dacc_pkg

// file: core/dacc_top.sv
// Clock divider, stabilizer tracking, output formatting and interleaved output
`timescale 1ns/1ps
module dacc_top #(
    parameter int IN_CLK_KHZ = 250000
) (
    input  wire logic                   core_clk,
    input  wire logic                   rstn,
    input  wire dacc_pkg::dacc_reg_req_t reg_req,
    output logic [7:0]                  reg_rdata,
    input  wire logic                   align_pulse,
    input  wire logic                   power_down_request,
    input  wire logic                   output_enable_n,
    input  wire logic [12:0]            adc_a_raw,
    input  wire logic [12:0]            adc_b_raw,
    output logic                        conv_clk,
    output logic                        dcs_active,
    output logic [10:0]                 data_out,
    output logic                        or_out,
    output logic                        data_oe,
    output logic                        data_capture_clock,
    output logic                        drive_reduced
);
    import dacc_pkg::*;

    dacc_state_t st;
    dacc_state_t next_st;

    // Clamp a raw signed sample to 11 bits, flag in bit 11
    // Full scale is -1024..1023; anything past either end pins to
    // the extreme code, so downstream never sees a wrapped value
    // and the flag is the only sign that clipping took place
    function automatic logic [11:0] clamp(input logic [12:0] raw);
        logic [11:0] r;
        r = {1'b0, raw[10:0]};
        if (!raw[12] && raw[11:10] != 2'b00) begin
            r = {1'b1, 11'h3ff};
        end else if (raw[12] && raw[11:10] != 2'b11) begin
            r = {1'b1, 11'h400};
        end
        return r;
    endfunction : clamp

    // Recode a two's complement word in the chosen format
    // Gray is built from offset binary, since Gray of a signed word
    // would jump across zero instead of stepping one bit at a time
    function automatic logic [10:0] recode(input logic [10:0] t, input logic [1:0] fmt);
        logic [10:0] ob;
        logic [10:0] r;
        ob = {~t[10], t[9:0]};
        r = t;
        if (fmt == FMT_OFFSET) begin
            r = ob;
        end else if (fmt == FMT_GRAY) begin
            r = ob ^ (ob >> 1);
        end
        return r;
    endfunction : recode

    // Channel samples packed so the pipeline loop can index them
    logic [1:0][12:0] raw;
    assign raw[0] = adc_a_raw;
    assign raw[1] = adc_b_raw;

    // One combinational pass computes every next value; defaults hold
    // the current state so fields not assigned below keep their value
    // Next-state logic for the whole block
    always_comb begin
        logic        pd;
        logic        run;
        logic        tick;
        logic        rise;
        logic        accept;
        logic        fast;
        logic [3:0]  ratio;
        logic [3:0]  hi_len;
        logic [1:0]  en;
        logic [11:0] pick;
        logic        rd_ch;
        pd = 1'b0;
        run = 1'b0;
        tick = 1'b0;
        rise = 1'b0;
        accept = 1'b0;
        fast = 1'b0;
        ratio = 4'h0;
        hi_len = 4'h0;
        en = 2'b00;
        pick = 12'h000;
        rd_ch = 1'b0;
        next_st = st;

        // Pins cross in from outside; only the second stage feeds logic
        // two-stage synchronisers
        next_st.align_sync = {st.align_sync[0], align_pulse};
        next_st.pd_sync    = {st.pd_sync[0], power_down_request};
        next_st.oen_sync   = {st.oen_sync[0], output_enable_n};
        next_st.align_prev = st.align_sync[1];

        // Power state: pin and register both force down; standby keeps drivers
        // register or pin request
        pd = (st.pwr_mode == PWR_DOWN) || st.pd_sync[1];
        run = !pd && (st.pwr_mode != PWR_STANDBY);
        ratio = {1'b0, st.div_sel} + 4'h1;
        tick = run && (st.div_cnt == st.div_sel);

        // A held pulse spans several cycles; only its leading edge may
        // restart the divider, or sampling would stall while it is high
        // one edge, one realign
        rise = st.align_sync[1] && !st.align_prev;
        // every pulse or first after write
        accept = rise && st.align_ctl[ALIGN_EN_BIT]
               && (!st.align_ctl[ALIGN_FIRST_BIT] || st.align_armed);
        if (accept && st.align_ctl[ALIGN_FIRST_BIT]) begin
            next_st.align_armed = 1'b0;
        end

        // Stopping the divider in standby parks it at zero, so wake-up
        // begins on a clean conversion edge
        // divider back to start
        if (!run || accept || tick) begin
            next_st.div_cnt = 3'h0;
        end else begin
            next_st.div_cnt = st.div_cnt + 3'h1;
        end

        // The stabilizer is modelled by its lock state only; the duty
        // cycle it restores shows as the high time of conv_clk
        // loop needs at least 40 MHz
        fast = IN_CLK_KHZ >= DCS_MIN_KHZ * int'(ratio);
        if (st.relock_cnt != 8'h00) begin
            next_st.relock_cnt = st.relock_cnt - 8'h01;
        end
        next_st.dcs_locked = (st.relock_cnt == 8'h00) && fast && !pd;
        next_st.dcs_active = st.dcs_en && st.dcs_locked;
        // half-period high when active, raw single cycle when bypassed
        hi_len = st.dcs_active ? ((ratio + 4'h1) >> 1) : 4'h1;
        next_st.conv_clk = run && ({1'b0, next_st.div_cnt} < hi_len);

        // Power-down empties the pipeline; standby leaves it frozen, so
        // the first words after standby are stale samples
        // Pipeline per channel
        for (int c = 0; c < 2; c++) begin
            if (pd) begin
                next_st.dl[c] = '0;
                next_st.word[c] = '0;
            end else if (tick) begin
                // clamp and flag; flag rides with code
                next_st.dl[c][0] = clamp(raw[c]);
                for (int i = 1; i < LAT_NSR; i++) begin
                    next_st.dl[c][i] = st.dl[c][i-1];
                end
                next_st.word[c] = st.nsr_en[c] ? st.dl[c][LAT_NSR-1] : st.dl[c][LAT_NORMAL-1];
            end
        end

        // Output stage: one shared bus, channel A in the high phase of
        // the capture clock and channel B in the low phase
        // per-channel disable
        en[0] = !st.out_mode[0][OM_DISABLE_BIT];
        en[1] = !st.out_mode[1][OM_DISABLE_BIT];
        // capture clock, A high phase, B low phase
        next_st.dcc = !st.dcc;
        if (en[0] && (next_st.dcc || !en[1])) begin
            pick = st.word[0];
            next_st.data_out = recode(pick[10:0], st.out_mode[0][1:0]);
        end else begin
            pick = st.word[1];
            next_st.data_out = recode(pick[10:0], st.out_mode[1][1:0]);
        end
        next_st.or_out = pick[11];
        // The pin is a slow control, so two cycles of sync delay are fine
        // three-state conditions
        next_st.data_oe = !pd && !st.oen_sync[1] && (en != 2'b00);
        next_st.drive_reduced = st.out_mode[0][OM_DRIVE_BIT];

        // Writes decoded in one chain; a write to an unmapped address
        // falls through and leaves everything unchanged
        // Register writes; per-channel ones follow the channel select
        if (reg_req.wr) begin
            if (reg_req.addr == ADDR_CHAN_SEL) begin
                next_st.chan_sel = reg_req.wdata[1:0];
            end else if (reg_req.addr == ADDR_POWER) begin
                next_st.pwr_mode = reg_req.wdata[1:0];
            end else if (reg_req.addr == ADDR_DCS) begin
                next_st.dcs_en = reg_req.wdata[0];
            end else if (reg_req.addr == ADDR_DIV) begin
                next_st.div_sel = reg_req.wdata[2:0];
                if (reg_req.wdata[2:0] != st.div_sel) begin
                    next_st.relock_cnt = RELOCK_CYC;
                    next_st.dcs_locked = 1'b0;
                end
            end else if (reg_req.addr == ADDR_ALIGN) begin
                next_st.align_ctl = reg_req.wdata;
                // rewrite rearms, beats a same-cycle accept
                next_st.align_armed = 1'b1;
            end else if (reg_req.addr == ADDR_OUT_MODE) begin
                for (int c = 0; c < 2; c++) begin
                    if (st.chan_sel[c]) begin
                        next_st.out_mode[c] = reg_req.wdata;
                    end
                end
            end else if (reg_req.addr == ADDR_NSR) begin
                for (int c = 0; c < 2; c++) begin
                    if (st.chan_sel[c]) begin
                        next_st.nsr_en[c] = reg_req.wdata[0];
                    end
                end
            end
        end

        // The read mux runs every cycle from the address alone, so a
        // host must hold the address one cycle before taking the byte
        // Channel select picks A for reads whenever its bit is set
        // Read data, one cycle after the address
        rd_ch = !st.chan_sel[0];
        if (reg_req.addr == ADDR_CHAN_SEL) begin
            next_st.rdata = {6'h00, st.chan_sel};
        end else if (reg_req.addr == ADDR_POWER) begin
            next_st.rdata = {6'h00, st.pwr_mode};
        end else if (reg_req.addr == ADDR_DCS) begin
            next_st.rdata = {7'h00, st.dcs_en};
        end else if (reg_req.addr == ADDR_DIV) begin
            next_st.rdata = {5'h00, st.div_sel};
        end else if (reg_req.addr == ADDR_STATUS) begin
            next_st.rdata = {4'h0, st.align_armed, pd, st.dcs_active, st.dcs_locked};
        end else if (reg_req.addr == ADDR_ALIGN) begin
            next_st.rdata = st.align_ctl;
        end else if (reg_req.addr == ADDR_OUT_MODE) begin
            next_st.rdata = st.out_mode[rd_ch];
        end else if (reg_req.addr == ADDR_NSR) begin
            next_st.rdata = {7'h00, st.nsr_en[rd_ch]};
        end else begin
            next_st.rdata = 8'h00;
        end
    end

    // Whole block state in one register; fields with non-zero reset
    // values are patched after the blanket clear
    // State register; reset values are constants only
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.chan_sel <= CHAN_SEL_RST;
            st.out_mode <= {OUT_MODE_RST, OUT_MODE_RST};
            st.align_ctl <= ALIGN_RST;
            st.pwr_mode <= PWR_NORMAL;
            st.dcs_en <= 1'b1;
            st.div_sel <= DIV_SEL_RST;
            st.relock_cnt <= RELOCK_CYC;
        end else begin
            st <= next_st;
        end
    end

    // Every output is a state field, so nothing combinational reaches
    // the pins and each changes only just after a clock edge
    // Outputs straight from state
    assign reg_rdata          = st.rdata;
    assign conv_clk           = st.conv_clk;
    assign dcs_active         = st.dcs_active;
    assign data_out           = st.data_out;
    assign or_out             = st.or_out;
    assign data_oe            = st.data_oe;
    assign data_capture_clock = st.dcc;
    assign drive_reduced      = st.drive_reduced;
endmodule : dacc_top

// file: test/dacc_checker.sv
// Port assertions for the converter control block
`timescale 1ns/1ps
module dacc_checker
    import dacc_pkg::*;
#(
    parameter int IN_CLK_KHZ = 250000
) (
    input wire logic                    core_clk,
    input wire logic                    rstn,
    input wire dacc_pkg::dacc_reg_req_t reg_req,
    input wire logic [7:0]              reg_rdata,
    input wire logic                    power_down_request,
    input wire logic                    output_enable_n,
    input wire logic                    dcs_active,
    input wire logic                    data_oe,
    input wire logic                    data_capture_clock
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic [2:0] div_q;
    logic       slow_rate;
    // Shadow of divider select, so a real rate change can be told from a rewrite
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) div_q <= DIV_SEL_RST;
        else if (reg_req.wr && reg_req.addr == ADDR_DIV) div_q <= reg_req.wdata[2:0];
    end
    assign slow_rate = (IN_CLK_KHZ / (int'(div_q) + 1)) < DCS_MIN_KHZ;
    sequence s_pd_held;
        power_down_request [*5];
    endsequence
    sequence s_align_wr_rd;
        $past(reg_req.wr) && $past(reg_req.addr) == ADDR_ALIGN && !reg_req.wr && reg_req.addr == ADDR_ALIGN;
    endsequence
    // Drivers, capture clock, register port and stabilizer
    a_pd_float: assert property (s_pd_held |-> !data_oe)
        else $error("data_oe high while powered down");
    a_pin_float: assert property (output_enable_n [*5] |-> !data_oe)
        else $error("data_oe high with enable pin high");
    a_dcc_toggle: assert property ($past(rstn) |-> data_capture_clock != $past(data_capture_clock))
        else $error("capture clock did not toggle");
    a_rd_unmapped: assert property (reg_req.addr == 8'h20 |=> reg_rdata == 8'h00)
        else $error("unmapped address read nonzero");
    a_align_readback: assert property (s_align_wr_rd |=> reg_rdata == $past(reg_req.wdata, 2))
        else $error("align register readback wrong");
    a_relock_wait: assert property (reg_req.wr && reg_req.addr == ADDR_DIV && reg_req.wdata[2:0] != div_q
        |-> ##3 !dcs_active [*8])
        else $error("stabilizer active during relock");
    a_slow_bypass: assert property (slow_rate [*4] |-> !dcs_active)
        else $error("stabilizer active below minimum rate");
    a_boot_lock: assert property ($rose(rstn) && !power_down_request |-> ##[1:140] dcs_active)
        else $error("stabilizer not active after reset");
endmodule : dacc_checker

bind dacc_top dacc_checker #(.IN_CLK_KHZ(IN_CLK_KHZ)) u_dacc_checker (
    .core_clk           (core_clk),
    .rstn               (rstn),
    .reg_req            (reg_req),
    .reg_rdata          (reg_rdata),
    .power_down_request (power_down_request),
    .output_enable_n    (output_enable_n),
    .dcs_active         (dcs_active),
    .data_oe            (data_oe),
    .data_capture_clock (data_capture_clock)
);

// file: test/dacc_capture_model.sv
// Receiving capture register for the interleaved output
`timescale 1ns/1ps
module dacc_capture_model (
    input wire logic        data_capture_clock,
    input wire logic [10:0] data_out,
    input wire logic        or_out,
    input wire logic        data_oe,
    output logic [11:0]     cap_a,
    output logic [11:0]     cap_b
);
    logic [11:0] bus = 12'h000;
    // Released drivers invert the bus at each input change, so it alternates between the last word and its complement
    always @(data_oe or data_out or or_out) begin
        if (data_oe) bus = {or_out, data_out};
        else bus = ~bus;
    end
    always @(posedge data_capture_clock) #20 cap_a <= bus;
    always @(negedge data_capture_clock) #20 cap_b <= bus;
endmodule : dacc_capture_model

// file: test/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench;
    import dacc_pkg::*;
    logic          core_clk, rstn, align_pulse, power_down_request, output_enable_n;
    dacc_reg_req_t reg_req;
    logic [7:0]    reg_rdata;
    logic [12:0]   adc_a_raw, adc_b_raw;
    logic          conv_clk, dcs_active, or_out, data_oe, data_capture_clock, drive_reduced;
    logic [10:0]   data_out;
    logic [11:0]   cap_a, cap_b;
    int            miscompares, checks_done, d0, d1, d2;
    logic [12:0]   raws [5] = '{13'h0155, 13'h0400, 13'h1400, 13'h03ff, 13'h1c00};

    dacc_top #(.IN_CLK_KHZ(250000)) u_dacc_top (
        .core_clk           (core_clk),
        .rstn               (rstn),
        .reg_req            (reg_req),
        .reg_rdata          (reg_rdata),
        .align_pulse        (align_pulse),
        .power_down_request (power_down_request),
        .output_enable_n    (output_enable_n),
        .adc_a_raw          (adc_a_raw),
        .adc_b_raw          (adc_b_raw),
        .conv_clk           (conv_clk),
        .dcs_active         (dcs_active),
        .data_out           (data_out),
        .or_out             (or_out),
        .data_oe            (data_oe),
        .data_capture_clock (data_capture_clock),
        .drive_reduced      (drive_reduced)
    );
    dacc_capture_model u_dacc_capture_model (
        .data_capture_clock (data_capture_clock),
        .data_out           (data_out),
        .or_out             (or_out),
        .data_oe            (data_oe),
        .cap_a              (cap_a),
        .cap_b              (cap_b)
    );

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        reg_req <= '{wr: 1'b1, addr: a, wdata: d};
        cyc(1);
        reg_req.wr <= 1'b0;
        cyc(1);
    endtask : reg_wr
    task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
        reg_req.addr <= a;
        cyc(1);
        @(negedge core_clk) check("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
        cyc(1);
    endtask : reg_chk
    task automatic oe_chk(input logic exp);
        cyc(4);
        #25 check("data_oe", {15'h0, data_oe}, {15'h0, exp});
        cyc(1);
    endtask : oe_chk
    // Expected word: flag on top, clamped code below
    function automatic logic [11:0] code(input logic [12:0] raw, input logic [1:0] fmt);
        logic [10:0] ob;
        logic        hi, lo;
        hi = $signed(raw) > 13'sd1023;
        lo = $signed(raw) < -13'sd1024;
        ob = hi ? 11'h7ff : lo ? 11'h000 : 11'(raw + 13'h0400);
        if (fmt == FMT_TWOS) ob = ob ^ 11'h400;
        if (fmt == FMT_GRAY) ob = ob ^ (ob >> 1);
        return {hi | lo, ob};
    endfunction : code
    // Bounded search for the next conversion clock rise, in core cycles
    task automatic to_rise(output int n);
        logic prev;
        // Start as if high, so a clock already high at the first look is not taken for a rise
        prev = 1'b1;
        for (n = 1; n < 40; n++) begin
            @(negedge core_clk);
            if (conv_clk && !prev) break;
            prev = conv_clk;
        end
        if (n == 40) begin
            miscompares++;
            end_of_test;
        end
        @(posedge core_clk);
    endtask : to_rise
    task automatic pulse_delay(input int k, output int n);
        cyc(k);
        align_pulse <= 1'b1;
        cyc(2);
        align_pulse <= 1'b0;
        cyc(6);
        to_rise(n);
    endtask : pulse_delay
    task automatic t_regs;
        reg_chk(ADDR_OUT_MODE, OUT_MODE_RST);
        reg_chk(ADDR_ALIGN, ALIGN_RST);
        reg_wr(8'h20, 8'h5a);
        reg_chk(8'h20, 8'h00);
        reg_wr(ADDR_OUT_MODE, 8'h09);
        reg_chk(ADDR_OUT_MODE, 8'h09);
        @(negedge core_clk) check("drive_reduced", {15'h0, drive_reduced}, 16'h0001);
        cyc(1);
        reg_wr(ADDR_OUT_MODE, 8'h01);
    endtask : t_regs
    task automatic t_float;
        output_enable_n <= 1'b1;
        oe_chk(1'b0);
        output_enable_n <= 1'b0;
        oe_chk(1'b1);
        power_down_request <= 1'b1;
        oe_chk(1'b0);
        power_down_request <= 1'b0;
        oe_chk(1'b1);
        reg_wr(ADDR_POWER, {6'h0, PWR_DOWN});
        oe_chk(1'b0);
        reg_wr(ADDR_POWER, {6'h0, PWR_STANDBY});
        oe_chk(1'b1);
        @(negedge core_clk) check("conv_clk standby", {15'h0, conv_clk}, 16'h0000);
        cyc(1);
        reg_wr(ADDR_POWER, {6'h0, PWR_NORMAL});
    endtask : t_float
    task automatic t_lat(input logic [1:0] fmt, input logic [12:0] raw, input int lat);
        reg_wr(ADDR_OUT_MODE, {6'h00, fmt});
        adc_a_raw <= 13'h0000;
        adc_b_raw <= 13'h0000;
        cyc(20);
        adc_a_raw <= raw;
        adc_b_raw <= raw;
        cyc(lat);
        #25 check("cap_a old", {4'h0, cap_a}, {4'h0, code(13'h0000, fmt)});
        cyc(3);
        #25 check("cap_a new", {4'h0, cap_a}, {4'h0, code(raw, fmt)});
        check("cap_b new", {4'h0, cap_b}, {4'h0, code(raw, fmt)});
        cyc(1);
    endtask : t_lat
    task automatic t_disable;
        reg_wr(ADDR_CHAN_SEL, 8'h02);
        reg_wr(ADDR_OUT_MODE, 8'h11);
        reg_chk(ADDR_OUT_MODE, 8'h11);
        adc_a_raw <= 13'h0155;
        adc_b_raw <= 13'h1e00;
        cyc(20);
        #25 check("cap_b", {4'h0, cap_b}, {4'h0, code(13'h0155, FMT_TWOS)});
        check("cap_a", {4'h0, cap_a}, {4'h0, code(13'h0155, FMT_TWOS)});
        cyc(1);
        reg_wr(ADDR_CHAN_SEL, 8'h01);
        reg_wr(ADDR_OUT_MODE, 8'h11);
        oe_chk(1'b0);
        reg_wr(ADDR_CHAN_SEL, 8'h03);
        reg_wr(ADDR_OUT_MODE, 8'h01);
    endtask : t_disable
    task automatic t_align;
        for (int d = 1; d < 8; d++) begin
            reg_wr(ADDR_DIV, 8'(d));
            to_rise(d0);
            to_rise(d1);
            check("conv period", 16'(d1), 16'(d + 1));
        end
        // Relock is long over, yet the rate is too low to lock
        cyc(140);
        @(negedge core_clk) check("dcs_active slow", {15'h0, dcs_active}, 16'h0000);
        cyc(1);
        reg_wr(ADDR_DIV, 8'h03);
        reg_wr(ADDR_ALIGN, 8'h02);
        pulse_delay(1, d1);
        pulse_delay(2, d2);
        check("align every", 16'(d1), 16'(d2));
        reg_wr(ADDR_ALIGN, 8'h06);
        pulse_delay(0, d0);
        pulse_delay(1, d1);
        pulse_delay(2, d2);
        check("align first", {15'h0, d1 != d2}, 16'h0001);
        reg_wr(ADDR_ALIGN, 8'h00);
        // Locked again at ratio 4: high for two of four cycles
        cyc(140);
        @(negedge core_clk) check("dcs_active relock", {15'h0, dcs_active}, 16'h0001);
        to_rise(d0);
        d1 = 0;
        repeat (4) begin
            @(negedge core_clk);
            d1 += int'(conv_clk);
        end
        check("conv high", 16'(d1), 16'h0002);
        cyc(1);
        reg_wr(ADDR_DIV, 8'h00);
    endtask : t_align

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Main sequence: quiet boot so the stabilizer can lock first
    initial begin
        rstn = 1'b0;
        reg_req = '0;
        align_pulse = 1'b0;
        power_down_request = 1'b0;
        output_enable_n = 1'b0;
        adc_a_raw = '0;
        adc_b_raw = '0;
        miscompares = 0;
        checks_done = 0;
        cyc(10);
        rstn <= 1'b1;
        cyc(140);
        @(negedge core_clk) check("dcs_active", {15'h0, dcs_active}, 16'h0001);
        cyc(1);
        t_regs();
        t_float();
        t_disable();
        for (int f = 0; f < 3; f++) begin
            foreach (raws[i]) t_lat(2'(f), raws[i], LAT_NORMAL);
        end
        reg_wr(ADDR_NSR, 8'h01);
        t_lat(FMT_TWOS, 13'h0155, LAT_NSR);
        reg_wr(ADDR_NSR, 8'h00);
        t_align();
        end_of_test();
    end
endmodule : testbench
